//--- fdc_ctl_regs.sv
// Drive output, tape assignment and rate select registers of the floppy controller.
//
// Chosen here: the address-and-strobe port.
`include "fdc_ctl_map.svh"
`timescale 1ns/10ps
module fdc_ctl_regs (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Register port.
  input wire logic [9:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Configuration inputs from same-clock logic.
  input wire logic [1:0] I_SYS_MODE,
  input wire logic I_TAPE_ENH_MODE,
  input wire logic I_DRIVE_SWAP,
  input wire logic [7:0] I_DRIVE_TYPE_CFG,
  input wire logic [1:0] I_BOOT_DRIVE,
  input wire logic I_CORE_ACCESS,
  // Drive pins.
  output logic O_DRIVE_SEL_0_N,
  output logic O_DRIVE_SEL_1_N,
  output logic O_MOTOR_OUT_0_N,
  output logic O_MOTOR_OUT_1_N,
  // Controller controls.
  output logic O_CORE_RESET,
  output logic O_DMA_IRQ_EN,
  output logic O_LOW_POWER,
  output logic [1:0] O_RATE_CODE,
  output logic [2:0] O_WRITE_SHIFT_CODE,
  output logic [15:0] O_WRITE_SHIFT_CODE_DELAY
);
  localparam logic [2:0] RST_CYC = 3'(`SOFT_RESET_CYCLES);
  logic [7:0] drive_output_control_ff;
  logic [1:0] tape_assignment_ff;
  logic [7:0] rate_and_write_shift_code_select_ff;
  logic [1:0] rate_code_ff;
  logic low_power_ff;
  logic pulse_on;
  logic pulse_start;
  fdc_ctl_pkg::rst_state_type rst_state_ff;
  logic [15:0] decoded_delay;
  logic [2:0] pulse_cnt_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [1:0] drive_num;
  logic sel0_raw;
  logic sel1_raw;
  logic wr_dor;
  logic wr_tape;
  logic wr_rate;
  logic wr_ccr;
  logic soft_reset;
  fdc_ctl_pkg::sys_mode_type mode;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  assign mode = fdc_ctl_pkg::sys_mode_type'(I_SYS_MODE);
  assign wr_dor = I_WR && hit(I_ADDR, `OFS_DRIVE_OUTPUT_CONTROL);
  assign wr_tape = I_WR && hit(I_ADDR, `OFS_TAPE_ASSIGNMENT);
  assign wr_rate = I_WR && hit(I_ADDR, `OFS_RATE_AND_WRITE_SHIFT_CODE_SELECT);
  assign wr_ccr = I_WR && hit(I_ADDR, `OFS_CONFIG_CONTROL_RATE);
  assign drive_num = drive_output_control_ff[1:0];

  // Drive output register; only a hardware reset clears it.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      drive_output_control_ff <= `RST_DRIVE_OUTPUT_CONTROL;
    end
    else if (wr_dor)
    begin
      drive_output_control_ff <= I_WDATA;
    end
  end

  // Tape select bits, untouched by software reset.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      tape_assignment_ff <= 2'h0;
    end
    else if (wr_tape)
    begin
      tape_assignment_ff <= I_WDATA[1:0];
    end
  end

  // Rate select register; self-clearing reset bit is not stored.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rate_and_write_shift_code_select_ff <= `RST_RATE_AND_WRITE_SHIFT_CODE_SELECT;
    end
    else if (wr_rate)
    begin
      rate_and_write_shift_code_select_ff <= {1'b0, I_WDATA[6], 1'b0, I_WDATA[4:0]};
    end
  end

  // Active data rate follows the latest write of either register.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rate_code_ff <= 2'(`RST_RATE_AND_WRITE_SHIFT_CODE_SELECT & 8'h03);
    end
    else if (wr_rate || wr_ccr)
    begin
      rate_code_ff <= I_WDATA[1:0];
    end
  end

  // A reset request from either register starts a pulse of minimum length.
  // Back to back zero and one writes would otherwise give a single cycle reset.
  assign pulse_start = (wr_rate && I_WDATA[`BIT_RATE_SOFT_RESET]) ||
                       (wr_dor && !I_WDATA[`BIT_SOFT_RESET_N]);

  // Reset pulse sequencer; the done state is the last cycle of the pulse.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rst_state_ff <= fdc_ctl_pkg::RST_IDLE_type_e;
    end
    else if (pulse_start)
    begin
      rst_state_ff <= fdc_ctl_pkg::RST_HOLD_type_e;
    end
    else
    begin
      case (rst_state_ff)
        fdc_ctl_pkg::RST_IDLE_type_e:
        begin
          rst_state_ff <= fdc_ctl_pkg::RST_IDLE_type_e;
        end
        fdc_ctl_pkg::RST_HOLD_type_e:
        begin
          if (pulse_cnt_ff == 3'h1)
          begin
            rst_state_ff <= fdc_ctl_pkg::RST_DONE_type_e;
          end
        end
        fdc_ctl_pkg::RST_DONE_type_e:
        begin
          rst_state_ff <= fdc_ctl_pkg::RST_IDLE_type_e;
        end
        default:
        begin
          rst_state_ff <= fdc_ctl_pkg::RST_IDLE_type_e;
        end
      endcase
    end
  end

  // Cycles left in the hold state of the reset pulse.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      pulse_cnt_ff <= 3'h0;
    end
    else if (pulse_start)
    begin
      pulse_cnt_ff <= RST_CYC - 3'h1;
    end
    else if (pulse_cnt_ff != 3'h0)
    begin
      pulse_cnt_ff <= pulse_cnt_ff - 3'h1;
    end
  end

  assign pulse_on = (rst_state_ff != fdc_ctl_pkg::RST_IDLE_type_e);
  assign soft_reset = !drive_output_control_ff[`BIT_SOFT_RESET_N] || pulse_on;

  // Manual low power, left on software reset or a core access.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      low_power_ff <= 1'b0;
    end
    else if (wr_rate && I_WDATA[`BIT_RATE_POWER_DOWN])
    begin
      low_power_ff <= 1'b1;
    end
    else if (soft_reset || I_CORE_ACCESS)
    begin
      low_power_ff <= 1'b0;
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (I_RD)
    begin
      if (hit(I_ADDR, `OFS_DRIVE_OUTPUT_CONTROL))
      begin
        nxt_rdata = drive_output_control_ff;
      end
      else if (hit(I_ADDR, `OFS_TAPE_ASSIGNMENT))
      begin
        if (I_TAPE_ENH_MODE)
        begin
          nxt_rdata = {2'h0, I_DRIVE_TYPE_CFG[{drive_num, 1'b0} +: 2], I_BOOT_DRIVE, tape_assignment_ff};
        end
        else
        begin
          nxt_rdata = {6'h00, tape_assignment_ff};
        end
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Drive select decode; drive numbers 2 and 3 have no select pin.
  always_comb
  begin
    sel0_raw = 1'b0;
    sel1_raw = 1'b0;
    case (drive_num)
      2'h0:
      begin
        sel0_raw = drive_output_control_ff[`BIT_MOTOR_ON_0];
      end
      2'h1:
      begin
        sel1_raw = drive_output_control_ff[`BIT_MOTOR_ON_1];
      end
      default:
      begin
        sel0_raw = 1'b0;
        sel1_raw = 1'b0;
      end
    endcase
  end

  // Drive pins, with optional swap of drives 0 and 1.
  always_comb
  begin
    if (I_DRIVE_SWAP)
    begin
      O_DRIVE_SEL_0_N = !sel1_raw;
      O_DRIVE_SEL_1_N = !sel0_raw;
      O_MOTOR_OUT_0_N = !drive_output_control_ff[`BIT_MOTOR_ON_1];
      O_MOTOR_OUT_1_N = !drive_output_control_ff[`BIT_MOTOR_ON_0];
    end
    else
    begin
      O_DRIVE_SEL_0_N = !sel0_raw;
      O_DRIVE_SEL_1_N = !sel1_raw;
      O_MOTOR_OUT_0_N = !drive_output_control_ff[`BIT_MOTOR_ON_0];
      O_MOTOR_OUT_1_N = !drive_output_control_ff[`BIT_MOTOR_ON_1];
    end
  end

  // DMA and interrupt gate by system mode.
  always_comb
  begin
    O_DMA_IRQ_EN = 1'b0;
    case (mode)
      fdc_ctl_pkg::MODE_AT:
      begin
        O_DMA_IRQ_EN = drive_output_control_ff[`BIT_DMA_IRQ_GATE];
      end
      fdc_ctl_pkg::MODE_ALT:
      begin
        O_DMA_IRQ_EN = drive_output_control_ff[`BIT_DMA_IRQ_GATE];
      end
      fdc_ctl_pkg::MODE_ENH:
      begin
        O_DMA_IRQ_EN = 1'b1;
      end
      default:
      begin
        O_DMA_IRQ_EN = drive_output_control_ff[`BIT_DMA_IRQ_GATE];
      end
    endcase
  end

  // The default precompensation is shorter at 1 Mbps than at the slower rates.
  always_comb
  begin
    if (rate_and_write_shift_code_select_ff[4:2] == 3'h0 && rate_code_ff == 2'h3)
    begin
      O_WRITE_SHIFT_CODE_DELAY = 16'h1047;
    end
    else
    begin
      O_WRITE_SHIFT_CODE_DELAY = decoded_delay;
    end
  end

  assign O_CORE_RESET = soft_reset;
  assign O_LOW_POWER = low_power_ff;
  assign O_RATE_CODE = rate_code_ff;
  assign O_WRITE_SHIFT_CODE = rate_and_write_shift_code_select_ff[4:2];
  assign O_RDATA = rdata_ff;

  fdc_write_shift_code_decode u_write_shift_code (
    .i_code(rate_and_write_shift_code_select_ff[4:2]),
    .i_fast(1'b0),
    .o_delay(decoded_delay)
  );
endmodule

//--- fdc_ctl_map.svh
// Register offsets, field positions, reset values and timing counts of the drive control register bank.
`ifndef FDC_CTL_MAP_SVH
`define FDC_CTL_MAP_SVH
`define OFS_DRIVE_OUTPUT_CONTROL 10'h3F2
`define OFS_TAPE_ASSIGNMENT 10'h3F3
`define OFS_RATE_AND_WRITE_SHIFT_CODE_SELECT 10'h3F4
`define OFS_CONFIG_CONTROL_RATE 10'h3F7
`define RST_DRIVE_OUTPUT_CONTROL 8'h00
`define RST_RATE_AND_WRITE_SHIFT_CODE_SELECT 8'h02
`define BIT_SOFT_RESET_N 2
`define BIT_DMA_IRQ_GATE 3
`define BIT_MOTOR_ON_0 4
`define BIT_MOTOR_ON_1 5
`define BIT_RATE_SOFT_RESET 7
`define BIT_RATE_POWER_DOWN 6
`define SOFT_RESET_MIN_NS 100
`define CLK_PERIOD_NS 20
`define SOFT_RESET_CYCLES ((`SOFT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- fdc_ctl_pkg.sv
// Types shared by the drive control register bank.
package fdc_ctl_pkg;
  typedef enum logic [1:0] {
    RST_IDLE_type_e = 2'h0,
    RST_HOLD_type_e = 2'h1,
    RST_DONE_type_e = 2'h3
  } rst_state_type;
  typedef enum logic [1:0] {
    MODE_AT = 2'h0,
    MODE_ALT = 2'h1,
    MODE_ENH = 2'h2
  } sys_mode_type;
endpackage

//--- fdc_write_shift_code_decode.sv
// Precompensation delay decode from code and data rate.
`timescale 1ns/10ps
module fdc_write_shift_code_decode (
  // Selection inputs.
  input wire logic [2:0] i_code,
  input wire logic i_fast,
  // Delay in hundredths of a nanosecond.
  output logic [15:0] o_delay
);
  logic [15:0] step;
  always_comb
  begin
    step = i_fast ? 16'h0820 : 16'h1047;
    if (i_code == 3'h7)
    begin
      o_delay = 16'h0000;
    end
    else if (i_code == 3'h0)
    begin
      o_delay = i_fast ? 16'h0820 : 16'h30D4;
    end
    else
    begin
      o_delay = 16'(step * {13'h0000, i_code});
    end
  end
endmodule

//--- fdc_drive_pair_model.sv
// Two floppy drives that spin up when selected with their motor on.
`timescale 1ns/10ps
module fdc_drive_pair_model (
  // Drive pins from the block.
  input wire logic i_sel_0_n,
  input wire logic i_sel_1_n,
  input wire logic i_mot_0_n,
  input wire logic i_mot_1_n,
  // Drive ready with motor running, one bit per drive.
  output logic [1:0] o_ready
);
  assign o_ready = {!i_sel_1_n && !i_mot_1_n, !i_sel_0_n && !i_mot_0_n};
endmodule

//--- fdc_ctl_regs_properties.sv
// Assertions on the ports of the drive control register bank.
`timescale 1ns/10ps
module fdc_ctl_regs_properties (
  // Clock, reset and register port.
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic [9:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Mode inputs and outputs.
  input wire logic [1:0] I_SYS_MODE,
  input wire logic I_DRIVE_SWAP,
  input wire logic O_MOTOR_OUT_0_N,
  input wire logic O_CORE_RESET,
  input wire logic O_DMA_IRQ_EN,
  input wire logic [1:0] O_RATE_CODE
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_B);
  logic wr_dor;
  logic wr_rate;
  assign wr_dor = I_WR && I_ADDR == 10'h3F2;
  assign wr_rate = I_WR && I_ADDR == 10'h3F4;
  chk_hw_reset_vals: assert property ($rose(I_RST_B) |-> O_RATE_CODE == 2'h2 && O_CORE_RESET)
    else $error("bad reset values");
  chk_dor_reset_stretch: assert property (wr_dor && !I_WDATA[2] |=> O_CORE_RESET [*5])
    else $error("drive output reset too short");
  chk_motor_follows_bit: assert property (
    wr_dor |=> O_MOTOR_OUT_0_N == !(I_DRIVE_SWAP ? $past(I_WDATA[5]) : $past(I_WDATA[4])))
    else $error("motor 0 wrong");
  chk_soft_reset_enter: assert property (wr_dor && !I_WDATA[2] |=> O_CORE_RESET)
    else $error("no core reset");
  chk_rate_reset_pulse: assert property (wr_rate && I_WDATA[7] |=> O_CORE_RESET [*5])
    else $error("short reset pulse");
  chk_dma_enh_on: assert property (wr_dor && I_SYS_MODE == 2'h2 |=> O_DMA_IRQ_EN)
    else $error("dma off in enhanced");
  chk_dma_legacy_gate: assert property (
    wr_dor && I_WDATA[2] && I_SYS_MODE != 2'h2 |=> O_DMA_IRQ_EN == $past(I_WDATA[3]))
    else $error("dma gate wrong");
  chk_rate_latest_write: assert property (
    wr_rate || I_WR && I_ADDR == 10'h3F7 |=> O_RATE_CODE == $past(I_WDATA[1:0]))
    else $error("rate not taken");
  chk_rate_reads_zero: assert property (I_RD && I_ADDR == 10'h3F4 |=> O_RDATA == 8'h00)
    else $error("rate read not zero");
endmodule
bind fdc_ctl_regs fdc_ctl_regs_properties u_props (.I_CORE_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .I_SYS_MODE, .I_DRIVE_SWAP, .O_MOTOR_OUT_0_N, .O_CORE_RESET, .O_DMA_IRQ_EN, .O_RATE_CODE);

//--- tb_floppy_drive_control_regs.sv
// Self-checking testbench of the drive control register bank.
`timescale 1ns/10ps
module tb_floppy_drive_control_regs;
  logic I_CORE_CLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic [9:0] I_ADDR = 10'h000;
  logic [7:0] I_WDATA = 8'h00;
  logic I_WR = 1'b0, I_RD = 1'b0, I_TAPE_ENH_MODE = 1'b0, I_DRIVE_SWAP = 1'b0, I_CORE_ACCESS = 1'b0;
  logic [1:0] I_SYS_MODE = 2'h0, I_BOOT_DRIVE = 2'h2, O_RATE_CODE, ready;
  logic [7:0] I_DRIVE_TYPE_CFG = 8'hE4, O_RDATA;
  logic O_DRIVE_SEL_0_N, O_DRIVE_SEL_1_N, O_MOTOR_OUT_0_N, O_MOTOR_OUT_1_N, O_CORE_RESET, O_DMA_IRQ_EN, O_LOW_POWER;
  logic [2:0] O_WRITE_SHIFT_CODE;
  logic [15:0] O_WRITE_SHIFT_CODE_DELAY;
  int bad_count = 0, compares = 0, cycles = 0;
  fdc_ctl_regs u_dut (.I_CORE_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_SYS_MODE,
    .I_TAPE_ENH_MODE, .I_DRIVE_SWAP, .I_DRIVE_TYPE_CFG, .I_BOOT_DRIVE, .I_CORE_ACCESS, .O_DRIVE_SEL_0_N,
    .O_DRIVE_SEL_1_N, .O_MOTOR_OUT_0_N, .O_MOTOR_OUT_1_N, .O_CORE_RESET, .O_DMA_IRQ_EN, .O_LOW_POWER,
    .O_RATE_CODE, .O_WRITE_SHIFT_CODE, .O_WRITE_SHIFT_CODE_DELAY);
  fdc_drive_pair_model u_drives (.i_sel_0_n(O_DRIVE_SEL_0_N), .i_sel_1_n(O_DRIVE_SEL_1_N),
    .i_mot_0_n(O_MOTOR_OUT_0_N), .i_mot_1_n(O_MOTOR_OUT_1_N), .o_ready(ready));
  task automatic wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CORE_CLK);
    I_WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
    @(posedge I_CORE_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CORE_CLK);
    I_RD <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, O_RDATA});
  endtask
  task automatic decode_test;
    logic [7:0] v [6] = '{8'h1C, 8'h2D, 8'hFE, 8'hCF, 8'h34, 8'h1D};
    logic [1:0] sel;
    logic [1:0] mot;
    for (int s = 0; s < 2; s++)
    begin
      I_DRIVE_SWAP <= s[0];
      foreach (v[i])
      begin
        wr(10'h3F2, v[i]);
        sel = {v[i][1:0] == 2'h1 && v[i][5], v[i][1:0] == 2'h0 && v[i][4]};
        mot = v[i][5:4];
        if (s == 1)
        begin
          sel = {sel[0], sel[1]};
          mot = {mot[0], mot[1]};
        end
        chk("selects", {14'h0, ~sel}, {14'h0, O_DRIVE_SEL_1_N, O_DRIVE_SEL_0_N});
        chk("motors", {14'h0, ~mot}, {14'h0, O_MOTOR_OUT_1_N, O_MOTOR_OUT_0_N});
        chk("drive ready", {14'h0, sel & mot}, {14'h0, ready});
        rd("dor readback", 10'h3F2, v[i]);
      end
    end
    I_DRIVE_SWAP <= 1'b0;
  endtask
  task automatic reset_test;
    wr(10'h3F3, 8'h02);
    wr(10'h3F4, 8'h01);
    wr(10'h3F2, 8'h18);
    chk("reset entered", 16'h1, {15'h0, O_CORE_RESET});
    wr(10'h3F2, 8'h1C);
    chk("reset held", 16'h1, {15'h0, O_CORE_RESET});
    tick(8);
    chk("reset ended", 16'h0, {15'h0, O_CORE_RESET});
    rd("dor kept", 10'h3F2, 8'h1C);
    rd("tape kept", 10'h3F3, 8'h02);
    chk("rate kept", 16'h1, {14'h0, O_RATE_CODE});
    wr(10'h3F4, 8'h83);
    chk("default fast", 16'h1047, O_WRITE_SHIFT_CODE_DELAY);
    tick(4);
    chk("pulse on", 16'h1, {15'h0, O_CORE_RESET});
    tick(1);
    chk("pulse off", 16'h0, {15'h0, O_CORE_RESET});
    rd("rate unreadable", 10'h3F4, 8'h00);
  endtask
  task automatic dma_test;
    for (int m = 0; m < 3; m++)
    begin
      I_SYS_MODE <= m[1:0];
      wr(10'h3F2, 8'h04);
      chk("dma off", {15'h0, m == 2}, {15'h0, O_DMA_IRQ_EN});
      wr(10'h3F2, 8'h0C);
      chk("dma on", 16'h1, {15'h0, O_DMA_IRQ_EN});
    end
    I_SYS_MODE <= 2'h0;
  endtask
  task automatic tape_rate_test;
    logic [2:0] cd [3] = '{3'h1, 3'h7, 3'h0};
    logic [15:0] dl [3] = '{16'h1047, 16'h0000, 16'h30D4};
    wr(10'h3F3, 8'hFF);
    rd("tape normal", 10'h3F3, 8'h03);
    I_TAPE_ENH_MODE <= 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      wr(10'h3F2, {6'h01, n[1:0]});
      rd("tape enhanced", 10'h3F3, {2'h0, I_DRIVE_TYPE_CFG[2 * n +: 2], I_BOOT_DRIVE, 2'h3});
    end
    foreach (cd[k])
    begin
      wr(10'h3F4, {3'h0, cd[k], 2'h2});
      chk("shift code", {13'h0, cd[k]}, {13'h0, O_WRITE_SHIFT_CODE});
      chk("shift delay", dl[k], O_WRITE_SHIFT_CODE_DELAY);
    end
    wr(10'h3F7, 8'h00);
    chk("ccr rate", 16'h0, {14'h0, O_RATE_CODE});
    wr(10'h3F4, 8'h42);
    chk("low power", 16'h1, {15'h0, O_LOW_POWER});
    I_CORE_ACCESS <= 1'b1;
    tick(1);
    I_CORE_ACCESS <= 1'b0;
    tick(1);
    chk("woken", 16'h0, {15'h0, O_LOW_POWER});
  endtask
  initial
  begin
    forever #10 I_CORE_CLK = ~I_CORE_CLK;
  end
  always @(posedge I_CORE_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    tick(3);
    I_RST_B <= 1'b1;
    tick(1);
    chk("core reset", 16'h1, {15'h0, O_CORE_RESET});
    chk("rate reset", 16'h2, {14'h0, O_RATE_CODE});
    rd("dor reset", 10'h3F2, 8'h00);
    rd("unmapped", 10'h3F0, 8'h00);
    decode_test();
    reset_test();
    dma_test();
    tape_rate_test();
    wrap_up();
  end
endmodule
